// ### design/port_io_defines.svh
`ifndef PORT_IO_DEFINES_SVH
`define PORT_IO_DEFINES_SVH

// ****************************************
// Data-memory map of the port registers
// ****************************************
`define FIRST_PORT_ADDR       8'h12
`define FIRST_PORT_DIR_ADDR   8'h13
`define SECOND_PORT_ADDR      8'h14
`define SECOND_PORT_DIR_ADDR  8'h15
`define THIRD_PORT_ADDR       8'h16
`define THIRD_PORT_DIR_ADDR   8'h17
`define FOURTH_PORT_ADDR      8'h18
`define FOURTH_PORT_DIR_ADDR  8'h19

// ****************************************
// Reset values and field positions
// ****************************************
`define DIR_RESET             8'hFF
`define DATA_RESET            8'h00
`define BUZZER_BIT            0
`define BUZZER_INV_BIT        1
`define DIVIDED_FREQ_BIT      3
`define EXT_INT_ZERO_BIT      4
`define EXT_INT_ONE_BIT       5
`define TIMER_ZERO_IN_BIT     6
`define TIMER_ONE_IN_BIT      7
`define TIMER_TWO_IN_BIT      0
`define UART_TX_BIT           6
`define UART_RX_BIT           7

`endif

// ### design/port_io_pkg.sv
package port_io_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [3:0] {
		BIT_SET   = 4'h1,
		BIT_CLEAR = 4'h2,
		COMPL     = 4'h4,
		COMPL_ACC = 4'h8
	} rmw_op_e;

	// Access from the CPU data-memory side.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       rmw;
		rmw_op_e    op;
		logic [2:0] bitSel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mem_req_s;

	// Shared-function selections fixed at build time.
	typedef struct packed {
		logic buzzerEn;
		logic dividedFreqEn;
		logic pwmEn;
	} share_cfg_s;

endpackage : port_io_pkg

// ### design/port_lane.sv
`timescale 1ns/1ps
`include "port_io_defines.svh"

// One 8-bit port: output latch, direction latch and pad read-back mux.
module port_lane #(
	parameter logic [7:0] DATA_ADDR = 8'h12,
	parameter logic [7:0] DIR_ADDR  = 8'h13
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             wrEn,
	input  wire logic [7:0]       wrAddr,
	input  wire logic [7:0]       wrData,
	input  wire logic [7:0]       padIn,
	output logic [7:0]            latch,
	output logic [7:0]            dir,
	output logic [7:0]            readVal
);
	import port_io_pkg::*;

	logic [7:0] latch_q;
	logic [7:0] dir_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			latch_q <= `DATA_RESET;
		end else if (wrEn && wrAddr == DATA_ADDR) begin
			latch_q <= wrData; // [R3]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dir_q <= `DIR_RESET; // [R7]
		end else if (wrEn && wrAddr == DIR_ADDR) begin
			dir_q <= wrData; // [R4] [R6]
		end
	end

	assign latch = latch_q;
	assign dir   = dir_q;
	// Pad is not latched; it is taken straight from the pin at read time.
	assign readVal = (padIn & dir_q) | (latch_q & ~dir_q); // [R2] [R5]

endmodule : port_lane

// ### design/quad_port_io.sv
`timescale 1ns/1ps
`include "port_io_defines.svh"

// Behaviour
// R1: Four 8-bit bidirectional ports, data registers at 12H, 14H, 16H, 18H.
// R2: Port input is not latched; pad sampled directly during the read.
// R3: Written output data held per bit until rewritten.
// R4: Direction bit 1 gives Schmitt input, 0 gives push-pull output.
// R5: Read returns pad for input bits and latch for output bits.
// R6: Direction registers at 13H, 15H, 17H, 19H pair with data below.
// R7: Reset sets all direction bits so every line is an input.
// R8: Set, clear and complement read whole port, modify, write back.
// R9: Every first-port line can raise a wake-up request; the code counts only lines whose direction bit is 1.
// R10: Shared pins: buzzer, divided frequency, interrupts, timers, UART.
// R11: Buzzer pair driven while latch bit 0 is 1; else forced 0.
// R12: Divided-frequency pin gated by latch bit 3 when output.
// R13: Divided-frequency signal toggles on each timer overflow.
// R14: Fourth-port bits 0..3 route PWM when latch bit 1, else 0.
// R15: Second-port pins also feed the A/D converter analog inputs.
// R16: Software should set unused lines as outputs to save power.
// R17: Shared-function and pull-up selections are static build-time inputs.
module quad_port_io (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire port_io_pkg::mem_req_s  req,
	output logic [7:0]                  rdata,
	output logic                        rdValid,
	output logic [7:0]                  accOut,
	output logic                        accValid,
	input  wire port_io_pkg::share_cfg_s shareCfg,
	input  wire logic [3:0]             pullUpCfg,
	input  wire logic                   buzzerSig,
	input  wire logic                   timerOverflow,
	input  wire logic                   timerOn,
	input  wire logic [3:0]             modulatedOutputs,
	input  wire logic                   powerDown,
	output logic                        wakeUp,
	input  wire logic [31:0]            padIn,
	output logic [31:0]                 padOut,
	output logic [31:0]                 padOe,
	output logic [31:0]                 padPullUp,
	output logic [7:0]                  analogSelect,
	output logic                        extInterruptZero_n,
	output logic                        extInterruptOne_n,
	output logic                        timerZeroInput,
	output logic                        timerOneInput,
	output logic                        timerTwoInput,
	output logic                        uartRx,
	input  wire logic                   uartTx,
	input  wire logic                   uartTxEn
);
	import port_io_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [7:0] apply_op(input logic [7:0] v, input rmw_op_e op,
		input logic [2:0] b);
		logic [7:0] m;
		m = 8'h01 << b;
		unique case (op)
			BIT_SET:   apply_op = v | m;
			BIT_CLEAR: apply_op = v & ~m;
			COMPL:     apply_op = ~v;
			COMPL_ACC: apply_op = ~v;
			default:   apply_op = v;
		endcase
	endfunction : apply_op

	function automatic logic is_port_data(input logic [7:0] a);
		is_port_data = (a == `FIRST_PORT_ADDR) || (a == `SECOND_PORT_ADDR) ||
			(a == `THIRD_PORT_ADDR) || (a == `FOURTH_PORT_ADDR);
	endfunction : is_port_data

	// ****************************************
	// Port lanes
	// ****************************************
	logic [31:0] latchAll;
	logic [31:0] dirAll;
	logic [31:0] readAll;
	logic        laneWr;
	logic [7:0]  laneData;
	logic [7:0]  selRead;

	port_lane #(.DATA_ADDR(`FIRST_PORT_ADDR), .DIR_ADDR(`FIRST_PORT_DIR_ADDR)) u_first (
		.clock(clock), .rst(rst), .wrEn(laneWr), .wrAddr(req.addr), .wrData(laneData),
		.padIn(padIn[7:0]), .latch(latchAll[7:0]), .dir(dirAll[7:0]),
		.readVal(readAll[7:0])); // [R1]
	port_lane #(.DATA_ADDR(`SECOND_PORT_ADDR), .DIR_ADDR(`SECOND_PORT_DIR_ADDR)) u_second (
		.clock(clock), .rst(rst), .wrEn(laneWr), .wrAddr(req.addr), .wrData(laneData),
		.padIn(padIn[15:8]), .latch(latchAll[15:8]), .dir(dirAll[15:8]),
		.readVal(readAll[15:8])); // [R1]
	port_lane #(.DATA_ADDR(`THIRD_PORT_ADDR), .DIR_ADDR(`THIRD_PORT_DIR_ADDR)) u_third (
		.clock(clock), .rst(rst), .wrEn(laneWr), .wrAddr(req.addr), .wrData(laneData),
		.padIn(padIn[23:16]), .latch(latchAll[23:16]), .dir(dirAll[23:16]),
		.readVal(readAll[23:16])); // [R1]
	port_lane #(.DATA_ADDR(`FOURTH_PORT_ADDR), .DIR_ADDR(`FOURTH_PORT_DIR_ADDR)) u_fourth (
		.clock(clock), .rst(rst), .wrEn(laneWr), .wrAddr(req.addr), .wrData(laneData),
		.padIn(padIn[31:24]), .latch(latchAll[31:24]), .dir(dirAll[31:24]),
		.readVal(readAll[31:24])); // [R1]

	// ****************************************
	// Read mux and read-modify-write
	// ****************************************
	always_comb begin
		unique case (req.addr)
			`FIRST_PORT_ADDR:      selRead = readAll[7:0];
			`FIRST_PORT_DIR_ADDR:  selRead = dirAll[7:0];
			`SECOND_PORT_ADDR:     selRead = readAll[15:8];
			`SECOND_PORT_DIR_ADDR: selRead = dirAll[15:8];
			`THIRD_PORT_ADDR:      selRead = readAll[23:16];
			`THIRD_PORT_DIR_ADDR:  selRead = dirAll[23:16];
			`FOURTH_PORT_ADDR:     selRead = readAll[31:24];
			`FOURTH_PORT_DIR_ADDR: selRead = dirAll[31:24];
			default:               selRead = 8'h00;
		endcase
	end

	// A read-modify-write sees the pad for input bits, so an input pin that
	// differs from its latch overwrites that latch; software must allow it.
	always_comb begin
		laneWr   = 1'b0;
		laneData = req.wdata;
		if (req.rmw && req.op != COMPL_ACC) begin
			laneWr   = 1'b1;
			laneData = apply_op(selRead, req.op, req.bitSel); // [R8]
		end else if (req.wr) begin
			laneWr = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata   <= 8'h00;
			rdValid <= 1'b0;
		end else begin
			rdata   <= selRead; // [R2] [R5]
			rdValid <= req.rd;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			accOut   <= 8'h00;
			accValid <= 1'b0;
		end else begin
			accOut   <= apply_op(selRead, COMPL_ACC, req.bitSel); // [R8]
			accValid <= req.rmw && req.op == COMPL_ACC && is_port_data(req.addr);
		end
	end

	// ****************************************
	// Divided-frequency generator
	// ****************************************
	logic divFreq_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			divFreq_q <= 1'b0;
		end else if (!timerOn) begin
			divFreq_q <= 1'b0;
		end else if (timerOverflow) begin
			divFreq_q <= ~divFreq_q; // [R13]
		end
	end

	// ****************************************
	// Pin drive with shared functions
	// ****************************************
	logic [31:0] outVal;

	always_comb begin
		outVal = latchAll;
		if (shareCfg.buzzerEn) begin // [R17]
			outVal[`BUZZER_BIT]     = latchAll[`BUZZER_BIT] & buzzerSig; // [R11]
			outVal[`BUZZER_INV_BIT] = latchAll[`BUZZER_BIT] & ~buzzerSig; // [R11]
		end
		if (shareCfg.dividedFreqEn) begin
			outVal[`DIVIDED_FREQ_BIT] = latchAll[`DIVIDED_FREQ_BIT] & divFreq_q; // [R12]
		end
		if (shareCfg.pwmEn) begin
			outVal[27:24] = latchAll[27:24] & modulatedOutputs; // [R14]
		end
		if (uartTxEn) begin
			outVal[16 + `UART_TX_BIT] = uartTx; // [R10]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			padOut <= 32'h0000_0000;
			padOe  <= 32'h0000_0000;
		end else begin
			padOut <= outVal;
			padOe  <= ~dirAll; // [R4]
		end
	end

	always_comb begin
		for (int p = 0; p < 4; p++) begin
			padPullUp[p*8 +: 8] = {8{pullUpCfg[p]}} & dirAll[p*8 +: 8]; // [R17]
		end
	end

	// ****************************************
	// Shared inputs and wake-up
	// ****************************************
	assign analogSelect       = dirAll[15:8]; // [R15]
	assign extInterruptZero_n = padIn[24 + `EXT_INT_ZERO_BIT]; // [R10]
	assign extInterruptOne_n  = padIn[24 + `EXT_INT_ONE_BIT];
	assign timerZeroInput     = padIn[24 + `TIMER_ZERO_IN_BIT];
	assign timerOneInput      = padIn[24 + `TIMER_ONE_IN_BIT];
	assign timerTwoInput      = padIn[16 + `TIMER_TWO_IN_BIT];
	assign uartRx             = padIn[16 + `UART_RX_BIT];

	// A wake-up is any change on a first-port input line while powered down.
	logic [7:0] firstPad_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			firstPad_q <= 8'h00;
			wakeUp     <= 1'b0;
		end else begin
			firstPad_q <= padIn[7:0];
			wakeUp     <= powerDown && |((firstPad_q ^ padIn[7:0]) & dirAll[7:0]); // [R9]
		end
	end

endmodule : quad_port_io

// ### verification/quad_port_io_properties.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module quad_port_io_checker
	import port_io_pkg::*;
(
	input wire logic			clock,
	input wire logic			rst,
	input wire port_io_pkg::mem_req_s	req,
	input wire logic [7:0]			rdata,
	input wire logic			rdValid,
	input wire logic			accValid,
	input wire port_io_pkg::share_cfg_s	shareCfg,
	input wire logic			timerOn,
	input wire logic [31:0]			padIn,
	input wire logic [31:0]			padOut,
	input wire logic [31:0]			padOe,
	input wire logic [7:0]			analogSelect
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence dirWrite;
		req.wr && !req.rmw && req.addr == 8'h13;
	endsequence
	sequence timerIdle;
		(shareCfg.dividedFreqEn && !timerOn)[*3];
	endsequence
	a_reset_input: assert property ($fell(rst) |-> padOe == 32'h0)
		else $error("pins driven after reset");
	a_read_valid: assert property (req.rd |=> rdValid)
		else $error("read without valid");
	a_unmapped_zero: assert property (req.rd && (req.addr < 8'h12 || req.addr > 8'h19)
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	a_dir_drives_oe: assert property (dirWrite |=> ##1 padOe[7:0] == ~$past(req.wdata, 2))
		else $error("direction not on enables");
	a_analog_dir: assert property (padOe[15:8] == ~$past(analogSelect))
		else $error("analog select mismatch");
	a_read_mux: assert property (req.rd && req.addr == 8'h14 |=> rdata ==
		(padOe[15:8] & padOut[15:8] | ~padOe[15:8] & $past(padIn[15:8])))
		else $error("read mux wrong");
	a_buzzer_pair: assert property (shareCfg.buzzerEn && padOe[1:0] == 2'h3
		|-> padOut[1:0] != 2'h3) else $error("buzzer pair not complementary");
	a_freq_idle: assert property (timerIdle |-> !(padOe[3] && padOut[3]))
		else $error("divided output high with timer off");
	a_acc_valid: assert property (req.rmw && req.op == COMPL_ACC && req.addr == 8'h14
		|=> accValid) else $error("no accumulator result");
endmodule : quad_port_io_checker

bind quad_port_io quad_port_io_checker chk (.clock, .rst, .req, .rdata, .rdValid,
	.accValid, .shareCfg, .timerOn, .padIn, .padOut, .padOe, .analogSelect);

// ### verification/pin_partner.sv
`timescale 1ns/1ps
// ****
// External pins
// ****
module pin_partner (
	input wire logic		clock,
	input wire logic [31:0]		padOut,
	input wire logic [31:0]		padOe,
	input wire logic [31:0]		padPullUp,
	input wire logic [31:0]		extVal,
	input wire logic [31:0]		extEn,
	output logic [31:0]		padIn
);
	logic [31:0] lastQ = 32'h0;
	// A floating pin flips each cycle so a stale level can never pass for data.
	always_ff @(posedge clock) begin
		lastQ <= padIn;
	end
	assign padIn = padOe & padOut | ~padOe & (extEn & extVal | ~extEn & (padPullUp | ~lastQ));
endmodule : pin_partner

// ### verification/quad_port_io_tb_top.sv
`timescale 1ns/1ps
// ****
// Testbench
// ****
module quad_port_io_tb_top;
	import port_io_pkg::*;
	logic		clock = 1'h0, rst = 1'h1, buzzerSig = 1'h0, timerOverflow = 1'h0;
	logic		timerOn = 1'h0, powerDown = 1'h0, b = 1'h0, w, uartTxEn = 1'h0;
	logic		rdValid, accValid, wakeUp, extInterruptZero_n, extInterruptOne_n;
	logic		timerZeroInput, timerOneInput, timerTwoInput, uartRx;
	mem_req_s	req = '0;
	share_cfg_s	shareCfg = 3'h7;
	logic [3:0]	modulatedOutputs = 4'h6;
	logic [7:0]	rdata, accOut, analogSelect, a;
	logic [31:0]	padIn, padOut, padOe, padPullUp, extEn = 32'hFFFF_FFFF;
	logic [31:0]	extVal = 32'h5A3C_C396;
	int		error_cnt = 0, check_count = 0;

	quad_port_io dut (.clock, .rst, .req, .rdata, .rdValid, .accOut, .accValid, .shareCfg,
		.pullUpCfg(4'h5), .buzzerSig, .timerOverflow, .timerOn, .modulatedOutputs,
		.powerDown, .wakeUp, .padIn, .padOut, .padOe, .padPullUp, .analogSelect,
		.extInterruptZero_n, .extInterruptOne_n, .timerZeroInput, .timerOneInput,
		.timerTwoInput, .uartRx, .uartTx(1'h0), .uartTxEn);
	pin_partner pins (.clock, .padOut, .padOe, .padPullUp, .extVal, .extEn, .padIn);

	always #2 clock = ~clock;

	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, d);
		@(negedge clock);
		req.wr = 1'h1;
		req.addr = ad;
		req.wdata = d;
		@(negedge clock);
		req = '0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, exp);
		@(negedge clock);
		req.rd = 1'h1;
		req.addr = ad;
		@(negedge clock);
		req = '0;
		chk("rdata", {24'h0, exp}, {24'h0, rdata});
	endtask : rd
	task automatic rmw(input rmw_op_e op, input logic [2:0] bs, input logic [7:0] ad);
		@(negedge clock);
		req.rmw = 1'h1;
		req.op = op;
		req.bitSel = bs;
		req.addr = ad;
		@(negedge clock);
		req = '0;
	endtask : rmw
	task automatic close_out();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (8) @(negedge clock);
		rst = 1'h0;
		for (a = 8'h12; a < 8'h1A; a += 8'h2) begin
			rd(a + 8'h1, 8'hFF);
			rd(a, extVal[4 * (a - 8'h12) +: 8]);
		end
		rd(8'h1A, 8'h00);
		// Every line becomes an output so no input is left floating.
		for (a = 8'h12; a < 8'h1A; a += 8'h2) begin
			wr(a, 8'hC3 ^ a);
			wr(a + 8'h1, 8'h00);
			rd(a, 8'hC3 ^ a);
		end
		chk("padOe", 32'hFFFF_FFFF, padOe);
		chk("portB", 8'hD7, padOut[15:8]);
		chk("portD", {4'hD, 4'hB & modulatedOutputs}, padOut[31:24]);
		// The transmit override must win over a latch bit that is 1.
		uartTxEn = 1'h1;
		repeat (2) @(negedge clock);
		chk("uartTx", 32'h0, padOut[22]);
		uartTxEn = 1'h0;
		repeat (2) begin
			buzzerSig = ~buzzerSig;
			repeat (2) @(negedge clock);
			chk("portA", {4'hD, 2'h0, ~buzzerSig, buzzerSig}, padOut[7:0]);
		end
		rmw(BIT_CLEAR, 3'h0, 8'h12);
		@(negedge clock);
		chk("buzzer", 2'h0, padOut[1:0]);
		rmw(BIT_SET, 3'h3, 8'h12);
		timerOn = 1'h1;
		repeat (2) begin
			b = ~b;
			timerOverflow = 1'h1;
			@(negedge clock);
			timerOverflow = 1'h0;
			repeat (3) @(negedge clock);
			chk("freq", b, padOut[3]);
		end
		rmw(COMPL, 3'h0, 8'h14);
		rd(8'h14, 8'h28);
		rmw(COMPL_ACC, 3'h0, 8'h14);
		chk("accOut", 8'hD7, accOut);
		rd(8'h14, 8'h28);
		rmw(BIT_SET, 3'h7, 8'h15);
		rd(8'h14, 8'hA8);
		chk("analog", 8'h80, analogSelect);
		rmw(BIT_SET, 3'h5, 8'h13);
		powerDown = 1'h1;
		@(negedge clock);
		extVal[5] = 1'h1;
		w = 1'h0;
		repeat (8) begin
			@(negedge clock);
			w |= wakeUp;
		end
		chk("wakeUp", 1'h1, w);
		wr(8'h17, 8'hFF);
		wr(8'h19, 8'hFF);
		chk("padPullUp", 32'h00FF_0020, padPullUp);
		rd(8'h18, 8'h5A);
		chk("shared", {extVal[31:28], extVal[16], extVal[23]}, {timerOneInput,
			timerZeroInput, extInterruptOne_n, extInterruptZero_n, timerTwoInput,
			uartRx});
		close_out();
	end

	initial begin
		#20000;
		error_cnt++;
		close_out();
	end
endmodule : quad_port_io_tb_top
